// ==== logic/mbrs_pkg.sv ====
// Constants, frame layout and check code step for the serial register slave
package mbrs_pkg;

	localparam int MB_CLK_HZ = 10_000_000;
	localparam int MB_BAUD = 115_200;
	localparam int MB_BIT_CYC = (MB_CLK_HZ + MB_BAUD / 2) / MB_BAUD;
	localparam int MB_CHAR_BITS = 10;
	localparam int MB_GAP_CHARS_X10 = 35;
	localparam int MB_GAP_CYC = (MB_GAP_CHARS_X10 * MB_CHAR_BITS * MB_BIT_CYC + 9) / 10;
	localparam int MB_REFRESH_HZ = 100;
	localparam int MB_REFRESH_CYC = MB_CLK_HZ / MB_REFRESH_HZ;

	localparam logic [6:0] MB_BIT_TOP = 7'(MB_BIT_CYC - 1);
	localparam logic [6:0] MB_BIT_HALF = 7'(MB_BIT_CYC / 2 - 1);
	localparam logic [11:0] MB_GAP_TOP = 12'(MB_GAP_CYC - 1);
	localparam logic [3:0] MB_STOP_POS = 4'h9;

	localparam logic [7:0] MB_SLAVE_ID = 8'h09;
	localparam logic [7:0] MB_FC_READ = 8'h03;
	localparam logic [7:0] MB_FC_WR1 = 8'h06;
	localparam logic [7:0] MB_FC_WRN = 8'h10;

	localparam logic [15:0] MB_CMD_BASE = 16'h03e8;
	localparam logic [15:0] MB_STAT_BASE = 16'h07d0;
	localparam logic [15:0] ACTION_AND_OPTIONS_WORD = 16'h03e8;
	localparam logic [15:0] POSITION_REQUEST_WORD = 16'h03e9;
	localparam logic [15:0] SPEED_FORCE_WORD = 16'h03ea;
	localparam logic [15:0] UNIT_AND_OBJECT_STATE_WORD = 16'h07d0;
	localparam logic [15:0] FAULT_AND_ECHO_WORD = 16'h07d1;
	localparam int MB_CMD_WORDS = 3;
	localparam logic [15:0] MB_CMD_COUNT = 16'h0003;
	localparam logic [15:0] MB_STAT_COUNT = 16'h0008;
	localparam logic [15:0] MB_CMD_RESET = 16'h0000;
	localparam logic [15:0] MB_INIT_VALUE = 16'h0100;
	localparam logic [15:0] MB_MAX_READ = 16'h0010;

	localparam logic [15:0] MB_CRC_INIT = 16'hffff;
	localparam logic [15:0] MB_CRC_POLY = 16'ha001;
	localparam logic [15:0] MB_CRC_GOOD = 16'h0000;

	localparam int MB_BUF_DEPTH = 32;
	localparam int MB_BUF_AW = 5;
	localparam logic [5:0] MB_BUF_LIMIT = 6'h20;
	localparam logic [5:0] MB_LEN_FIXED = 6'h08;
	localparam logic [8:0] MB_LEN_WRN_HDR = 9'h009;
	localparam logic [7:0] MB_DATA_POS = 8'h07;
	localparam logic [5:0] MB_RD_DATA_POS = 6'h03;
	localparam logic [5:0] MB_RD_OVERHEAD = 6'h05;
	localparam logic [5:0] MB_ECHO_LEN = 6'h08;

	function automatic logic [15:0] mbrs_crc_step(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ MB_CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	function automatic logic mbrs_in_block(input logic [15:0] addr, input logic [15:0] base, input logic [15:0] words);
		logic [15:0] off;
		off = addr - base;
		return off < words;
	endfunction

endpackage

// ==== logic/mbrs_mem_if.sv ====
// Carrier between the frame engine and its frame byte store
`timescale 1ns/1ns
interface mbrs_mem_if import mbrs_pkg::*;;
	logic wr_en;
	logic [MB_BUF_AW-1:0] wr_addr;
	logic [7:0] wr_data;
	logic [MB_BUF_AW-1:0] rd_addr;
	logic [7:0] rd_data;
	modport owner(output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport store(input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ==== logic/mbrs_frame_mem.sv ====
// Frame byte store with registered read data
`timescale 1ns/1ns
module mbrs_frame_mem import mbrs_pkg::*; (
	input wire logic sys_clk_i,
	mbrs_mem_if.store mem
);
	logic [7:0] cells [MB_BUF_DEPTH];

	// Contents need no reset, every byte is written before it is read
	always_ff @(posedge sys_clk_i) begin
		if (mem.wr_en) begin
			cells[mem.wr_addr] <= mem.wr_data;
		end
		mem.rd_data <= cells[mem.rd_addr];
	end
endmodule

// ==== logic/mbrs_slave.sv ====
// Serial register slave: receiver, frame check, command store, reply sender
// Operation
// - Line runs 115200 baud, 8N1
// - Answer only slave address 9
// - Accept function codes 3, 6, 16 only
// - Never send exception replies
// - Command words start at 0x03E8
// - Status words start at 0x07D0
// - One word is two consecutive device bytes
// - Lower numbered byte goes high
// - Read reply: id, 3, byte count, data, check
// - Single write stores value, echoes request
// - Multi write reply: id, 16, start, count, check
// - Every frame ends with serial check code
// - Status values refreshed at 100 Hz
// - 0x0100 at 0x03E8 requests initialisation
`timescale 1ns/1ns
module mbrs_slave import mbrs_pkg::*; #(
	parameter int REFRESH_CYCLES = MB_REFRESH_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic rx_i,
	output logic tx_o,
	output logic tx_en_o,
	input wire logic [127:0] status_bytes_i,
	output logic [47:0] cmd_words_o,
	output logic [7:0] action_req_o,
	output logic [7:0] options_o,
	output logic cmd_update_o,
	output logic init_req_o
);
	typedef enum logic [1:0] {ST_RECV, ST_COMMIT, ST_REPLY} mbrs_state_e;

	mbrs_state_e state;
	mbrs_mem_if mem();

	logic rx_busy;
	logic [6:0] rx_cnt;
	logic [3:0] rx_bit;
	logic [7:0] rx_shift;
	logic rx_done;
	logic rx_ferr;
	logic [11:0] gap_cnt;
	logic in_frame;
	logic f_bad;
	logic [5:0] ri;
	logic [15:0] rx_crc;
	logic [7:0] f_slave;
	logic [7:0] f_fc;
	logic [15:0] f_addr;
	logic [15:0] f_qty;
	logic [7:0] f_bc;
	logic [15:0] cmd [MB_CMD_WORDS];
	logic [127:0] snap;
	logic [16:0] snap_cnt;
	logic [7:0] cm_j;
	logic [7:0] cm_pos;
	logic cm_valid;
	logic [7:0] cm_hi;
	logic tx_busy;
	logic [6:0] tx_cnt;
	logic [3:0] tx_left;
	logic [8:0] tx_shift;
	logic [5:0] tx_idx;
	logic [15:0] tx_crc;

	mbrs_frame_mem u_mem (
		.sys_clk_i(sys_clk_i),
		.mem(mem)
	);

	// Frame end and acceptance
	wire eof = in_frame && state == ST_RECV && gap_cnt == MB_GAP_TOP;
	wire crc_ok = rx_crc == MB_CRC_GOOD;
	wire [8:0] wrn_len = 9'(f_bc) + MB_LEN_WRN_HDR;
	wire rd_ok = f_fc == MB_FC_READ && ri == MB_LEN_FIXED && f_qty != 16'h0000 && f_qty <= MB_MAX_READ;
	wire w1_ok = f_fc == MB_FC_WR1 && ri == MB_LEN_FIXED;
	wire wn_ok = f_fc == MB_FC_WRN && 9'(ri) == wrn_len && ri <= MB_BUF_LIMIT && f_qty != 16'h0000
		&& f_qty[15:7] == 9'h000 && {f_qty[6:0], 1'b0} == f_bc;
	// Anything else is dropped without a word, never an exception frame
	wire frame_ok = eof && !f_bad && crc_ok && f_slave == MB_SLAVE_ID && (rd_ok || w1_ok || wn_ok);

	// Command word writes from a single write or from the multi write walk
	wire w1_now = frame_ok && f_fc == MB_FC_WR1;
	wire wn_now = state == ST_COMMIT && cm_valid && cm_pos[0];
	wire [15:0] wn_addr = f_addr + {8'h00, 1'b0, cm_pos[7:1]};
	wire cmd_we = w1_now || wn_now;
	wire [15:0] cmd_waddr = w1_now ? f_addr : wn_addr;
	wire [15:0] cmd_wval = w1_now ? f_qty : {cm_hi, mem.rd_data};
	wire cmd_hit = mbrs_in_block(cmd_waddr, MB_CMD_BASE, MB_CMD_COUNT);
	wire [15:0] cmd_woff = cmd_waddr - MB_CMD_BASE;
	wire commit_done = state == ST_COMMIT && cm_valid && cm_pos == f_bc - 8'h01;

	// Reply byte selection
	wire is_read = f_fc == MB_FC_READ;
	wire [5:0] tx_len = is_read ? MB_RD_OVERHEAD + {f_qty[4:0], 1'b0} : MB_ECHO_LEN;
	wire [5:0] rel = tx_idx - MB_RD_DATA_POS;
	wire [15:0] rd_waddr = f_addr + {11'h000, rel[5:1]};
	wire [15:0] stat_off = rd_waddr - MB_STAT_BASE;
	wire [15:0] cmd_roff = rd_waddr - MB_CMD_BASE;
	wire stat_hit = mbrs_in_block(rd_waddr, MB_STAT_BASE, MB_STAT_COUNT);
	wire cmd_rhit = mbrs_in_block(rd_waddr, MB_CMD_BASE, MB_CMD_COUNT);
	wire [7:0] stat_byte = snap[{stat_off[2:0], rel[0], 3'b000} +: 8];
	wire [15:0] cmd_rword = cmd_roff[1:0] == 2'h0 ? cmd[0] : cmd_roff[1:0] == 2'h1 ? cmd[1] : cmd[2];
	wire [7:0] cmd_byte = rel[0] ? cmd_rword[7:0] : cmd_rword[15:8];
	wire [7:0] rd_byte = stat_hit ? stat_byte : cmd_rhit ? cmd_byte : 8'h00;
	wire [7:0] echo_byte = tx_idx == 6'h02 ? f_addr[15:8] : tx_idx == 6'h03 ? f_addr[7:0] :
		tx_idx == 6'h04 ? f_qty[15:8] : f_qty[7:0];
	wire is_crc_lo = tx_idx == tx_len - 6'h02;
	wire is_crc_hi = tx_idx == tx_len - 6'h01;
	wire [7:0] body_byte = is_read ? (tx_idx == 6'h02 ? {f_qty[6:0], 1'b0} : rd_byte) : echo_byte;
	wire [7:0] tx_data = tx_idx == 6'h00 ? MB_SLAVE_ID : tx_idx == 6'h01 ? f_fc : is_crc_lo ? tx_crc[7:0] :
		is_crc_hi ? tx_crc[15:8] : body_byte;
	wire tx_go = state == ST_REPLY && !tx_busy && tx_idx != tx_len;

	assign mem.wr_en = rx_done && state == ST_RECV && ri < MB_BUF_LIMIT;
	assign mem.wr_addr = ri[MB_BUF_AW-1:0];
	assign mem.wr_data = rx_shift;
	assign mem.rd_addr = MB_BUF_AW'(MB_DATA_POS + cm_j);

	assign cmd_words_o = {cmd[2], cmd[1], cmd[0]};
	assign action_req_o = cmd[0][15:8];
	assign options_o = cmd[0][7:0];

	// Receiver, mid bit sampling; ignores the line while replying
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_busy <= 1'b0;
			rx_cnt <= 7'h00;
			rx_bit <= 4'h0;
			rx_shift <= 8'h00;
			rx_done <= 1'b0;
			rx_ferr <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			rx_ferr <= 1'b0;
			if (!rx_busy) begin
				if (!rx_i && state == ST_RECV) begin
					rx_busy <= 1'b1;
					rx_cnt <= MB_BIT_HALF;
					rx_bit <= 4'h0;
				end
			end else if (rx_cnt != 7'h00) begin
				rx_cnt <= rx_cnt - 7'h01;
			end else begin
				rx_cnt <= MB_BIT_TOP;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit == 4'h0 && rx_i) begin
					rx_busy <= 1'b0;
				end else if (rx_bit < MB_STOP_POS) begin
					rx_shift <= {rx_i, rx_shift[7:1]};
				end else begin
					rx_busy <= 1'b0;
					rx_done <= rx_i;
					rx_ferr <= !rx_i;
				end
			end
		end
	end

	// Line silence timer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gap_cnt <= 12'h000;
		end else if (rx_busy || !rx_i) begin
			gap_cnt <= 12'h000;
		end else if (gap_cnt != MB_GAP_TOP) begin
			gap_cnt <= gap_cnt + 12'h001;
		end
	end

	// Header capture and running check code over the whole frame
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_frame <= 1'b0;
			f_bad <= 1'b0;
			ri <= 6'h00;
			rx_crc <= MB_CRC_INIT;
			f_slave <= 8'h00;
			f_fc <= 8'h00;
			f_addr <= 16'h0000;
			f_qty <= 16'h0000;
			f_bc <= 8'h00;
		end else if (eof) begin
			in_frame <= 1'b0;
			f_bad <= 1'b0;
			ri <= 6'h00;
			rx_crc <= MB_CRC_INIT;
		end else begin
			if (rx_ferr) begin
				f_bad <= 1'b1;
			end
			if (rx_done && state == ST_RECV) begin
				in_frame <= 1'b1;
				ri <= ri == 6'h3f ? ri : ri + 6'h01;
				rx_crc <= mbrs_crc_step(rx_crc, rx_shift);
				case (ri)
					6'h00: f_slave <= rx_shift;
					6'h01: f_fc <= rx_shift;
					6'h02: f_addr[15:8] <= rx_shift;
					6'h03: f_addr[7:0] <= rx_shift;
					6'h04: f_qty[15:8] <= rx_shift;
					6'h05: f_qty[7:0] <= rx_shift;
					6'h06: f_bc <= rx_shift;
					default: ;
				endcase
			end
		end
	end

	// Sequencer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_RECV;
		end else begin
			case (state)
				ST_RECV: begin
					if (frame_ok) begin
						state <= f_fc == MB_FC_WRN ? ST_COMMIT : ST_REPLY;
					end
				end
				ST_COMMIT: begin
					if (commit_done) begin
						state <= ST_REPLY;
					end
				end
				default: begin
					if (!tx_busy && tx_idx == tx_len) begin
						state <= ST_RECV;
					end
				end
			endcase
		end
	end

	// Walk the stored data bytes; read data lag one cycle behind the address
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cm_j <= 8'h00;
			cm_pos <= 8'h00;
			cm_valid <= 1'b0;
			cm_hi <= 8'h00;
		end else if (state != ST_COMMIT) begin
			cm_j <= 8'h00;
			cm_valid <= 1'b0;
		end else begin
			cm_j <= cm_j + 8'h01;
			cm_pos <= cm_j;
			cm_valid <= 1'b1;
			if (cm_valid && !cm_pos[0]) begin
				cm_hi <= mem.rd_data;
			end
		end
	end

	// Command words; writes outside the block are dropped but still answered
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int k = 0; k < MB_CMD_WORDS; k++) begin
				cmd[k] <= MB_CMD_RESET;
			end
			cmd_update_o <= 1'b0;
			init_req_o <= 1'b0;
		end else begin
			for (int k = 0; k < MB_CMD_WORDS; k++) begin
				if (cmd_we && cmd_hit && cmd_woff == 16'(k)) begin
					cmd[k] <= cmd_wval;
				end
			end
			cmd_update_o <= cmd_we && cmd_hit;
			init_req_o <= cmd_we && cmd_waddr == ACTION_AND_OPTIONS_WORD && cmd_wval == MB_INIT_VALUE;
		end
	end

	// Status snapshot; held during a reply so a word is never torn
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			snap <= 128'h0;
			snap_cnt <= 17'h00000;
		end else if (snap_cnt == 17'(REFRESH_CYCLES - 1)) begin
			if (state != ST_REPLY) begin
				snap <= status_bytes_i;
				snap_cnt <= 17'h00000;
			end
		end else begin
			snap_cnt <= snap_cnt + 17'h00001;
		end
	end

	// Reply byte feeder and transmitter
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_busy <= 1'b0;
			tx_cnt <= 7'h00;
			tx_left <= 4'h0;
			tx_shift <= 9'h1ff;
			tx_o <= 1'b1;
			tx_en_o <= 1'b0;
			tx_idx <= 6'h00;
			tx_crc <= MB_CRC_INIT;
		end else begin
			tx_en_o <= state == ST_REPLY;
			if (state != ST_REPLY) begin
				tx_idx <= 6'h00;
				tx_crc <= MB_CRC_INIT;
			end else if (tx_go) begin
				tx_idx <= tx_idx + 6'h01;
				if (!is_crc_lo && !is_crc_hi) begin
					tx_crc <= mbrs_crc_step(tx_crc, tx_data);
				end
			end
			if (tx_go) begin
				tx_busy <= 1'b1;
				tx_o <= 1'b0;
				tx_shift <= {1'b1, tx_data};
				tx_left <= MB_STOP_POS;
				tx_cnt <= MB_BIT_TOP;
			end else if (tx_busy) begin
				if (tx_cnt != 7'h00) begin
					tx_cnt <= tx_cnt - 7'h01;
				end else if (tx_left == 4'h0) begin
					tx_busy <= 1'b0;
				end else begin
					tx_o <= tx_shift[0];
					tx_shift <= {1'b1, tx_shift[8:1]};
					tx_left <= tx_left - 4'h1;
					tx_cnt <= MB_BIT_TOP;
				end
			end
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	start_bit_a: assert property ($rose(tx_busy) |-> !tx_o [*8])
		else $error("start bit too short");
	slave_match_a: assert property (frame_ok |-> f_slave == MB_SLAVE_ID)
		else $error("frame for another slave accepted");
	func_set_a: assert property (frame_ok |-> f_fc == MB_FC_READ || f_fc == MB_FC_WR1 || f_fc == MB_FC_WRN)
		else $error("unsupported function accepted");
	no_except_a: assert property (tx_go && tx_idx == 6'h01 |-> !tx_data[7])
		else $error("exception function code sent");
	byte_count_a: assert property (tx_go && tx_idx == 6'h02 && is_read |-> tx_data == {f_qty[6:0], 1'b0})
		else $error("wrong read byte count");
	status_high_a: assert property (tx_go && is_read && tx_idx == 6'h03 && f_addr == MB_STAT_BASE
		|-> tx_data == snap[7:0])
		else $error("status byte 0 not in upper half");
	multi_reply_a: assert property (tx_go && f_fc == MB_FC_WRN && tx_idx == 6'h05 |-> tx_data == f_qty[7:0]
		&& tx_len == MB_ECHO_LEN)
		else $error("bad multi write reply");
	crc_drop_a: assert property (eof && !crc_ok |=> state == ST_RECV [*2])
		else $error("bad check code frame not dropped");
	init_pulse_a: assert property (cmd_we && cmd_waddr == ACTION_AND_OPTIONS_WORD && cmd_wval == MB_INIT_VALUE
		|=> init_req_o && cmd[0] == MB_INIT_VALUE)
		else $error("initialisation request missed");
	single_store_a: assert property (w1_now && cmd_hit
		|=> cmd_words_o[{$past(cmd_woff[1:0]), 4'h0} +: 16] == $past(f_qty))
		else $error("single write not stored");
	refresh_a: assert property (state != ST_REPLY && snap_cnt == 17'(REFRESH_CYCLES - 1)
		|=> snap == $past(status_bytes_i) && snap_cnt == 17'h00000)
		else $error("status refresh missed");
endmodule

// ==== logic/mbrs_end.sv ====
// No logic lives in this file

// ==== verif/mbrs_master.sv ====
// Bus master model: frame sender with check code, reply collector
`timescale 1ns/1ns
module mbrs_master (
	input wire logic sys_clk_i,
	output logic tx_o,
	input wire logic rx_i
);
	localparam int BIT_CYC = 87;
	logic [7:0] req[$];
	logic [7:0] rsp[$];
	int bad_stop;

	initial begin
		tx_o = 1'b1;
		bad_stop = 0;
	end

	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
			end
		end
		return c;
	endfunction

	// Appends the check code, flipped in bit 0 when bad is set
	task automatic send(input logic bad);
		logic [15:0] c;
		logic [9:0] ch;
		// Spacing scaled down together with the refresh period
		repeat (100) @(posedge sys_clk_i);
		#1;
		c = crc16(req) ^ {15'h0000, bad};
		req.push_back(c[7:0]);
		req.push_back(c[15:8]);
		foreach (req[i]) begin
			ch = {1'b1, req[i], 1'b0};
			for (int k = 0; k < 10; k++) begin
				tx_o = ch[k];
				repeat (BIT_CYC) @(posedge sys_clk_i);
				#1;
			end
		end
	endtask

	// Sampled on the falling edge, away from the reply line's updates
	task automatic recv(input int wait_cyc);
		int n;
		logic [7:0] d;
		rsp.delete();
		n = 0;
		while (n < wait_cyc) begin
			@(negedge sys_clk_i);
			n++;
			if (rx_i === 1'b0) begin
				repeat (43) @(negedge sys_clk_i);
				for (int k = 0; k < 8; k++) begin
					repeat (BIT_CYC) @(negedge sys_clk_i);
					d[k] = rx_i;
				end
				repeat (BIT_CYC) @(negedge sys_clk_i);
				if (rx_i !== 1'b1)
					bad_stop++;
				rsp.push_back(d);
				n = wait_cyc - 300;
			end
		end
	endtask
endmodule

// ==== verif/modbus_rtu_register_slave_tb.sv ====
// Testbench for the serial register slave
`timescale 1ns/1ns
module modbus_rtu_register_slave_tb import mbrs_pkg::*;;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	wire rx_line;
	wire tx_line;
	logic tx_en;
	logic [127:0] status;
	logic [47:0] cmd_words;
	logic [7:0] act;
	logic [7:0] opt;
	logic upd;
	logic init;
	int n_mismatch = 0;
	int checks_done = 0;
	int n_init = 0;
	int n_upd = 0;
	int cycles = 0;
	logic [7:0] exp[$];

	always #50 sys_clk_i = ~sys_clk_i;

	mbrs_slave #(.REFRESH_CYCLES(50)) dut (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.rx_i(rx_line),
		.tx_o(tx_line),
		.tx_en_o(tx_en),
		.status_bytes_i(status),
		.cmd_words_o(cmd_words),
		.action_req_o(act),
		.options_o(opt),
		.cmd_update_o(upd),
		.init_req_o(init)
	);

	mbrs_master master (
		.sys_clk_i(sys_clk_i),
		.tx_o(rx_line),
		.rx_i(tx_line)
	);

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Pulses are one cycle wide, so each counts once
	always @(negedge sys_clk_i) begin
		cycles++;
		if (init === 1'b1)
			n_init++;
		if (upd === 1'b1)
			n_upd++;
		if (tx_en !== 1'b1 && tx_line !== 1'b1) begin
			n_mismatch++;
			$display("FAIL idle line expected 1 seen %b", tx_line);
		end
		if (cycles == 98000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic check(input string what, input logic [47:0] e, input logic [47:0] s);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic check_reply();
		check("reply length", 48'(exp.size()), 48'(master.rsp.size()));
		check("driver off", 48'd0, 48'(tx_en));
		foreach (exp[i]) begin
			if (i < master.rsp.size())
				check("reply byte", 48'(exp[i]), 48'(master.rsp[i]));
		end
	endtask

	task automatic add_crc();
		logic [15:0] c;
		c = master.crc16(exp);
		exp.push_back(c[7:0]);
		exp.push_back(c[15:8]);
	endtask

	// A dropped frame must leave the line and the command word alone
	task automatic dropped(input logic bad, input string name);
		master.send(bad);
		master.recv(3400);
		check("silent drop", 48'd0, 48'(master.rsp.size()));
		check("word 0 kept", 48'h0100, 48'(cmd_words[15:0]));
		$display("test %s done", name);
	endtask

	initial begin
		for (int k = 0; k < 16; k++) begin
			status[8*k +: 8] = 8'(8'he0 + 8'(k * 3));
		end
		repeat (5) @(posedge sys_clk_i);
		#1;
		rst_n_i = 1'b1;
		check("word 0 reset", 48'h0000, 48'(cmd_words[15:0]));

		master.req = '{MB_SLAVE_ID, MB_FC_WR1, 8'h03, 8'he8, 8'h01, 8'h00};
		master.send(1'b0);
		exp = master.req;
		master.recv(4000);
		check("model code", 48'h0962, 48'({exp[6], exp[7]}));
		check_reply();
		check("word 0", 48'h0100, 48'(cmd_words[15:0]));
		check("action byte", 48'h01, 48'(act));
		check("options byte", 48'h00, 48'(opt));
		check("init pulses", 48'd1, 48'(n_init));
		$display("test single write done");

		master.req = '{MB_SLAVE_ID, MB_FC_WRN, 8'h03, 8'he9, 8'h00, 8'h02, 8'h04, 8'h00, 8'he6, 8'h3c, 8'hc8};
		master.send(1'b0);
		master.recv(4000);
		exp = '{MB_SLAVE_ID, MB_FC_WRN, 8'h03, 8'he9, 8'h00, 8'h02};
		add_crc();
		check("model code", 48'h9130, 48'({exp[6], exp[7]}));
		check_reply();
		check("words 1 2", 48'h3cc800e6, 48'(cmd_words[47:16]));
		check("update pulses", 48'd3, 48'(n_upd));
		check("init pulses", 48'd1, 48'(n_init));
		$display("test multi write done");

		// New inputs must reach the snapshot before the read is answered
		@(posedge sys_clk_i);
		#1;
		for (int k = 0; k < 16; k++) begin
			status[8*k +: 8] = 8'(8'h11 + 8'(k * 5));
		end
		master.req = '{MB_SLAVE_ID, MB_FC_READ, 8'h07, 8'hd0, 8'h00, 8'h02};
		master.send(1'b0);
		master.recv(4000);
		check("model code", 48'hc5ce, 48'({master.req[6], master.req[7]}));
		exp = '{MB_SLAVE_ID, MB_FC_READ, 8'h04, status[7:0], status[15:8], status[23:16], status[31:24]};
		add_crc();
		check_reply();
		$display("test status read done");

		master.req = '{MB_SLAVE_ID, MB_FC_WR1, 8'h03, 8'he8, 8'h02, 8'h00};
		dropped(1'b1, "bad check code");
		master.req = '{8'h0a, MB_FC_WR1, 8'h03, 8'he8, 8'h02, 8'h00};
		dropped(1'b0, "other address");
		master.req = '{MB_SLAVE_ID, 8'h04, 8'h03, 8'he8, 8'h00, 8'h01};
		dropped(1'b0, "unknown function");
		check("stop bits", 48'd0, 48'(master.bad_stop));
		report_and_stop();
	end
endmodule
